// ===== shared/measure_extend_defines.svh
/*
  constants for the measurement-extend leaf block: register offsets,
  field positions, reset values, check masks and hash header layout.
  assumes inclusion by bare name from the package and the design file.
*/
`ifndef MEASURE_EXTEND_DEFINES_SVH
`define MEASURE_EXTEND_DEFINES_SVH

// apb byte offsets of the register words
`define OFS_CTRL        8'h00
`define OFS_CPTR_LO     8'h04
`define OFS_CPTR_HI     8'h08
`define OFS_CHUNK_LO    8'h0C
`define OFS_CHUNK_HI    8'h10
`define OFS_SEG_LIMIT   8'h14
`define OFS_STATUS      8'h18
`define OFS_COUNT_LO    8'h1C
`define OFS_COUNT_HI    8'h20
`define OFS_OFFSET_LO   8'h24
`define OFS_OFFSET_HI   8'h28

// control word fields
`define CTRL_START      0
`define CTRL_MODE64     1
`define CTRL_PROT       2
`define CTRL_PRIV_LO    4
`define CTRL_PRIV_HI    5

// status word fields
`define ST_BUSY         0
`define ST_DONE         1
`define ST_GP           2
`define ST_PF           3
`define ST_PF_CHUNK     4
`define ST_CAUSE_LO     8
`define ST_CAUSE_HI     11
`define ST_ERR_LO       16
`define ST_ERR_HI       31

// reset values and checks
`define ZERO32          32'h0000_0000
`define ZERO64          64'h0000_0000_0000_0000
`define PRIV_TOP        2'h0
`define CTL_ALIGN_MASK  64'h0000_0000_0000_0FFF
`define CHUNK_ALIGN_MASK 64'h0000_0000_0000_00FF
`define PAGE_LOW_MASK   64'h0000_0000_0000_0FFF
`define CHUNK_LAST      32'h0000_00FF
`define CANON_HI        63
`define CANON_LO        47
`define QUARTER_BYTES   64'h0000_0000_0000_0040
`define QUARTER_LAST    2'h3
`define GP_ERROR_CODE   16'h0000

// header block layout
`define HDR_TAG         64'h0044_4E45_5458_4545
`define HDR_PAD         384'h0
`define CNT_HDR_INC     64'h0000_0000_0000_0001
`define CNT_DATA_INC    64'h0000_0000_0000_0004

// page type codes in the metadata map
`define PT_REGULAR      8'h01
`define PT_THREAD_CTL   8'h02
`define SHADOW_STACK_FIRST_TYPE_T   8'h03
`define SHADOW_STACK_REST_TYPE_T    8'h04

`endif

// ===== shared/measure_extend_pkg.sv
/*
  types for the measurement-extend leaf block: sequencer states and
  fault causes. assumes the defines header is on the include path.
*/
package measure_extend_pkg;
  `include "measure_extend_defines.svh"

  // sequencer states, gray coded along idle-check-fetch-header-data
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CHECK = 3'b001,
    ST_FETCH = 3'b011,
    ST_HDR   = 3'b010,
    ST_DATA  = 3'b110
  } seq_state_e;

  // reason recorded when the operation faults
  typedef enum logic [3:0] {
    C_NONE        = 4'h0,
    C_PRIVILEGE   = 4'h1,
    C_CANONICAL   = 4'h2,
    C_SEG_LIMIT   = 4'h3,
    C_CTL_ALIGN   = 4'h4,
    C_CTL_NOT_PC  = 4'h5,
    C_CHK_ALIGN   = 4'h6,
    C_CHK_NOT_PC  = 4'h7,
    C_MAP_BUSY    = 4'h8,
    C_CHK_INVALID = 4'h9,
    C_BAD_TYPE    = 4'hA,
    C_WRONG_OWNER = 4'hB,
    C_MEAS_BUSY   = 4'hC,
    C_INITIALIZED = 4'hD,
    C_ACCESS      = 4'hE
  } fault_cause_e;
endpackage

// ===== rtl/measure_extend_leaf.sv
/*
  measurement-extend leaf: apb registers, operand checks, chunk fetch and
  sequencing of five hash updates into the enclave measurement.
  assumes page-cache lookups, the metadata map, memory and the sha-256
  core sit outside on the same clock and answer by the ports below.
*/
`timescale 1ns/1ps
`include "measure_extend_defines.svh"

module measure_extend_leaf (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         ctl_in_cache,
  input  wire logic         chunk_in_cache,
  input  wire logic         map_busy,
  input  wire logic         chunk_entry_valid,
  input  wire logic [7:0]   chunk_page_type,
  input  wire logic         owner_match,
  input  wire logic         measure_busy,
  input  wire logic         enclave_initialized,
  input  wire logic [63:0]  page_enclave_addr,
  input  wire logic [63:0]  enclave_base,
  output logic              mem_req,
  output logic [63:0]       mem_addr,
  input  wire logic         mem_ack,
  input  wire logic [511:0] mem_rdata,
  input  wire logic         mem_fault,
  input  wire logic [15:0]  mem_fault_code,
  output logic              hash_req,
  output logic [511:0]      hash_block,
  input  wire logic         hash_ack,
  output logic [63:0]       update_count
);
  import measure_extend_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // declarations
  seq_state_e   state;             // sequencer state
  fault_cause_e cause;             // recorded fault reason
  fault_cause_e check_cause;       // combinational check result
  logic [63:0]  cptr;              // control page pointer
  logic [63:0]  chunk;             // chunk pointer
  logic [31:0]  seg_limit;         // data segment limit
  logic         mode64;            // 64-bit addressing mode
  logic         prot_mode;         // protected mode limit checking
  logic [1:0]   priv;              // current privilege level
  logic         busy;              // operation in flight
  logic         done;              // sticky completion flag
  logic         gp_flag;           // last run ended in protection fault
  logic         pf_flag;           // last run ended in page fault
  logic         pf_chunk;          // page fault named the chunk pointer
  logic [15:0]  err_code;          // fault error code
  logic [63:0]  enclave_offset;    // offset of chunk in enclave
  logic [1:0]   quarter;           // quarter index for fetch and hash
  logic [511:0] chunk_buf [0:3];   // fetched chunk, four quarters
  logic         wr_en;             // apb write strobe
  logic         rd_setup;          // apb read setup phase
  logic         start_pulse;       // software start request
  logic         clr_done;          // software done clear
  logic         addr_hit;          // address decodes to a register
  logic [31:0]  next_rdata;        // read mux output
  logic         canon_bad;         // non-canonical pointer
  logic         limit_bad;         // pointer beyond segment limit
  logic         type_ok;           // accepted page type
  logic         fetch_fault;       // memory fault during fetch
  logic         check_pf;          // failing check is a page fault
  logic         check_on_chunk;    // failing check names the chunk

  ////////////////////////////////////////////////////////////////////////
  // apb decode, zero wait state
  assign pready      = 1'b1;
  assign wr_en       = psel & penable & pwrite;
  assign rd_setup    = psel & ~penable & ~pwrite;
  assign start_pulse = wr_en & (paddr == `OFS_CTRL) & pwdata[`CTRL_START];
  assign clr_done    = wr_en & (paddr == `OFS_STATUS) & pwdata[`ST_DONE];

  // address decode for the error answer
  always_comb begin
    case (paddr)
      `OFS_CTRL, `OFS_CPTR_LO, `OFS_CPTR_HI, `OFS_CHUNK_LO,
      `OFS_CHUNK_HI, `OFS_SEG_LIMIT, `OFS_STATUS, `OFS_COUNT_LO,
      `OFS_COUNT_HI, `OFS_OFFSET_LO, `OFS_OFFSET_HI: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // unmapped address answers with an error in the access phase
  assign pslverr = psel & penable & ~addr_hit;

  // read mux, unmapped reads give zero
  always_comb begin
    next_rdata = `ZERO32;
    case (paddr)
      `OFS_CTRL: begin
        next_rdata[`CTRL_MODE64]                 = mode64;
        next_rdata[`CTRL_PROT]                   = prot_mode;
        next_rdata[`CTRL_PRIV_HI:`CTRL_PRIV_LO]  = priv;
      end
      `OFS_CPTR_LO:   next_rdata = cptr[31:0];
      `OFS_CPTR_HI:   next_rdata = cptr[63:32];
      `OFS_CHUNK_LO:  next_rdata = chunk[31:0];
      `OFS_CHUNK_HI:  next_rdata = chunk[63:32];
      `OFS_SEG_LIMIT: next_rdata = seg_limit;
      `OFS_STATUS: begin
        next_rdata[`ST_BUSY]                     = busy;
        next_rdata[`ST_DONE]                     = done;
        next_rdata[`ST_GP]                       = gp_flag;
        next_rdata[`ST_PF]                       = pf_flag;
        next_rdata[`ST_PF_CHUNK]                 = pf_chunk;
        next_rdata[`ST_CAUSE_HI:`ST_CAUSE_LO]    = cause;
        next_rdata[`ST_ERR_HI:`ST_ERR_LO]        = err_code;
      end
      `OFS_COUNT_LO:  next_rdata = update_count[31:0];
      `OFS_COUNT_HI:  next_rdata = update_count[63:32];
      `OFS_OFFSET_LO: next_rdata = enclave_offset[31:0];
      `OFS_OFFSET_HI: next_rdata = enclave_offset[63:32];
      default:        next_rdata = `ZERO32;
    endcase
  end

  // read data captured in the setup cycle, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `ZERO32;
    end else if (rd_setup) begin
      prdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software operands, frozen while an operation runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cptr      <= `ZERO64;
      chunk     <= `ZERO64;
      seg_limit <= `ZERO32;
      mode64    <= 1'b0;
      prot_mode <= 1'b0;
      priv      <= `PRIV_TOP;
    end else if (wr_en && !busy) begin
      case (paddr)
        `OFS_CTRL: begin
          mode64    <= pwdata[`CTRL_MODE64];
          prot_mode <= pwdata[`CTRL_PROT];
          priv      <= pwdata[`CTRL_PRIV_HI:`CTRL_PRIV_LO];
        end
        `OFS_CPTR_LO:   cptr[31:0]   <= pwdata;
        `OFS_CPTR_HI:   cptr[63:32]  <= pwdata;
        `OFS_CHUNK_LO:  chunk[31:0]  <= pwdata;
        `OFS_CHUNK_HI:  chunk[63:32] <= pwdata;
        `OFS_SEG_LIMIT: seg_limit    <= pwdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operand checks, evaluated in one cycle before any hash update
  // canonical form: upper address bits all copies of the top valid bit
  assign canon_bad = mode64 &&
    ((|cptr[`CANON_HI:`CANON_LO] && !(&cptr[`CANON_HI:`CANON_LO])) ||
     (|chunk[`CANON_HI:`CANON_LO] && !(&chunk[`CANON_HI:`CANON_LO])));

  // segment limit: whole chunk and control page base within the limit
  assign limit_bad = prot_mode && !mode64 &&
    ((|cptr[63:32]) || (|chunk[63:32]) || (cptr[31:0] > seg_limit) ||
     ({1'b0, chunk[31:0]} + {1'b0, `CHUNK_LAST} > {1'b0, seg_limit}));

  // page types that may be measured, thread control pages included; unused pages are not
  assign type_ok = (chunk_page_type == `PT_REGULAR) ||
                   (chunk_page_type == `PT_THREAD_CTL) ||
                   (chunk_page_type == `SHADOW_STACK_FIRST_TYPE_T) ||
                   (chunk_page_type == `SHADOW_STACK_REST_TYPE_T);

  // first failing check wins, in operand order
  always_comb begin
    check_cause = C_NONE;
    if (priv != `PRIV_TOP) begin
      check_cause = C_PRIVILEGE;
    end else if (canon_bad) begin
      check_cause = C_CANONICAL;
    end else if (limit_bad) begin
      check_cause = C_SEG_LIMIT;
    end else if (|(cptr & `CTL_ALIGN_MASK)) begin
      check_cause = C_CTL_ALIGN;
    end else if (!ctl_in_cache) begin
      check_cause = C_CTL_NOT_PC;
    end else if (|(chunk & `CHUNK_ALIGN_MASK)) begin
      check_cause = C_CHK_ALIGN;
    end else if (!chunk_in_cache) begin
      check_cause = C_CHK_NOT_PC;
    end else if (map_busy) begin
      check_cause = C_MAP_BUSY;
    end else if (!chunk_entry_valid) begin
      check_cause = C_CHK_INVALID;
    end else if (!type_ok) begin
      check_cause = C_BAD_TYPE;
    end else if (!owner_match) begin
      check_cause = C_WRONG_OWNER;
    end else if (measure_busy) begin
      check_cause = C_MEAS_BUSY;
    end else if (enclave_initialized) begin
      check_cause = C_INITIALIZED;
    end
  end

  // page faults name a pointer; everything else is a protection fault
  assign check_pf = (check_cause == C_CTL_NOT_PC) ||
                    (check_cause == C_CHK_NOT_PC) ||
                    (check_cause == C_CHK_INVALID) ||
                    (check_cause == C_BAD_TYPE);
  assign check_on_chunk = (check_cause != C_CTL_NOT_PC);
  assign fetch_fault    = (state == ST_FETCH) && mem_ack && mem_fault;

  ////////////////////////////////////////////////////////////////////////
  // sequencer: check, fetch all four quarters, then header and data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= ST_IDLE;
      quarter <= 2'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          quarter <= 2'h0;
          if (start_pulse) begin
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (check_cause == C_NONE) begin
            state <= ST_FETCH;
          end else begin
            state <= ST_IDLE;
          end
        end
        // chunk is read fully before hashing so a late fault changes nothing
        ST_FETCH: begin
          if (fetch_fault) begin
            state <= ST_IDLE;
          end else if (mem_ack) begin
            quarter <= quarter + 2'h1;
            if (quarter == `QUARTER_LAST) begin
              state <= ST_HDR;
            end
          end
        end
        ST_HDR: begin
          if (hash_ack) begin
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (hash_ack) begin
            quarter <= quarter + 2'h1;
            if (quarter == `QUARTER_LAST) begin
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign busy     = (state != ST_IDLE);
  assign mem_req  = (state == ST_FETCH);
  assign hash_req = (state == ST_HDR) || (state == ST_DATA);

  // quarter address, lowest first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr <= `ZERO64;
    end else if (state == ST_CHECK) begin
      mem_addr <= chunk;
    end else if (state == ST_FETCH && mem_ack) begin
      mem_addr <= mem_addr + `QUARTER_BYTES;
    end
  end

  // fetched quarters held for the data updates
  always_ff @(posedge pclk) begin
    if (state == ST_FETCH && mem_ack && !mem_fault) begin
      chunk_buf[quarter] <= mem_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // enclave offset, taken when checks pass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enclave_offset <= `ZERO64;
    end else if (state == ST_CHECK && check_cause == C_NONE) begin
      enclave_offset <= page_enclave_addr - enclave_base +
                        (chunk & `PAGE_LOW_MASK);
    end
  end

  // block presented to the hash core, held until acknowledged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hash_block <= 512'h0;
    end else if (state == ST_FETCH && mem_ack && !mem_fault &&
                 quarter == `QUARTER_LAST) begin
      hash_block <= {`HDR_PAD, enclave_offset, `HDR_TAG};
    end else if (hash_ack && state == ST_HDR) begin
      hash_block <= chunk_buf[0];
    end else if (hash_ack && state == ST_DATA && quarter != `QUARTER_LAST) begin
      hash_block <= chunk_buf[quarter + 2'h1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // measurement update counter, loadable by software when idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      update_count <= `ZERO64;
    end else if (state == ST_HDR && hash_ack) begin
      update_count <= update_count + `CNT_HDR_INC;
    end else if (state == ST_DATA && hash_ack && quarter == `QUARTER_LAST) begin
      update_count <= update_count + `CNT_DATA_INC;
    end else if (wr_en && !busy && paddr == `OFS_COUNT_LO) begin
      update_count[31:0] <= pwdata;
    end else if (wr_en && !busy && paddr == `OFS_COUNT_HI) begin
      update_count[63:32] <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outcome flags; done sticks until cleared, a new finish wins the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
    end else if ((state == ST_CHECK && check_cause != C_NONE) || fetch_fault ||
                 (state == ST_DATA && hash_ack && quarter == `QUARTER_LAST)) begin
      done <= 1'b1;
    end else if (clr_done) begin
      done <= 1'b0;
    end
  end

  // fault kind, pointer and code of the last run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gp_flag  <= 1'b0;
      pf_flag  <= 1'b0;
      pf_chunk <= 1'b0;
      cause    <= C_NONE;
      err_code <= `GP_ERROR_CODE;
    end else if (state == ST_CHECK) begin
      gp_flag  <= (check_cause != C_NONE) && !check_pf;
      pf_flag  <= check_pf;
      pf_chunk <= check_pf && check_on_chunk;
      cause    <= check_cause;
      err_code <= `GP_ERROR_CODE;
    end else if (fetch_fault) begin
      pf_flag  <= 1'b1;
      pf_chunk <= 1'b1;
      cause    <= C_ACCESS;
      err_code <= mem_fault_code;
    end
  end

endmodule // measure_extend_leaf

// ===== verification/measure_extend_monitor.sv
/*
  port checks on the extend leaf: fetch order, hash order, counter steps.
  assumes a bind onto measure_extend_leaf and its single clock.
*/
`timescale 1ns/1ps
`include "measure_extend_defines.svh"
module measure_extend_monitor (
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic         mem_req,
  input wire logic [63:0]  mem_addr,
  input wire logic         mem_ack,
  input wire logic         mem_fault,
  input wire logic         hash_req,
  input wire logic [511:0] hash_block,
  input wire logic         hash_ack,
  input wire logic [63:0]  update_count
);
  logic       hdr_now;  // hash port carries a header block
  logic [1:0] dq;       // data quarters hashed since the header
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign hdr_now = hash_block[63:0] == `HDR_TAG && hash_block[511:128] == '0;
  // count data quarters taken by the hash side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq <= 2'h0;
    end else if (hash_req && hash_ack) begin
      dq <= hdr_now ? 2'h0 : dq + 2'h1;
    end
  end
  ////////////////////////////////////////
  sequence s_quarter; mem_req && mem_ack && !mem_fault; endsequence
  sequence s_fault; mem_req && mem_ack && mem_fault; endsequence
  sequence s_hdr_ack; hash_req && hash_ack && hdr_now; endsequence
  sequence s_last_ack; hash_req && hash_ack && !hdr_now && dq == 2'h3; endsequence
  AST_FETCH_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("fetch request moved before ack");
  AST_QUARTER_STEP: assert property (s_quarter ##1 mem_req |->
    mem_addr == $past(mem_addr) + `QUARTER_BYTES) else $error("quarter address step wrong");
  AST_NO_HASH_IN_FETCH: assert property (mem_req |-> !hash_req)
    else $error("hash started before chunk fetched");
  AST_FAULT_NO_HASH: assert property (s_fault |=> !hash_req [*4])
    else $error("hash after fetch fault");
  AST_HEADER_FIRST: assert property ($rose(hash_req) |-> hdr_now)
    else $error("first hash block not header");
  AST_HASH_HOLD: assert property (hash_req && !hash_ack |=>
    hash_req && $stable(hash_block)) else $error("hash block moved before ack");
  AST_HDR_COUNT: assert property (s_hdr_ack |=> update_count == $past(update_count) + 1)
    else $error("counter not plus one after header");
  AST_DATA_COUNT: assert property (s_last_ack |=> update_count == $past(update_count) + 4)
    else $error("counter not plus four after data");
  AST_COUNT_QUIET: assert property (!hash_ack && !(psel && penable && pwrite) |=>
    $stable(update_count)) else $error("counter moved without hash ack");
endmodule // measure_extend_monitor
bind measure_extend_leaf measure_extend_monitor u_mon (.pclk, .presetn, .psel, .penable,
  .pwrite, .mem_req, .mem_addr, .mem_ack, .mem_fault, .hash_req, .hash_block, .hash_ack,
  .update_count);

// ===== verification/measure_extend_partner.sv
/*
  far side model: chunk memory and hash core, answering after zero idle cycles, or when slow
  after two for a first request and one for a request that follows an ack. assumes requests are held until acknowledged.
*/
`timescale 1ns/1ps
module measure_extend_partner #(
  parameter logic [15:0] FCODE = 16'h5A3C  // fault code handed back, arbitrary
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         slow,
  input  wire logic         inject,
  input  wire logic         mem_req,
  input  wire logic [63:0]  mem_addr,
  output logic              mem_ack,
  output logic [511:0]      mem_rdata,
  output logic              mem_fault,
  output logic [15:0]       mem_fault_code,
  input  wire logic         hash_req,
  output logic              hash_ack
);
  logic [1:0] mw, hw;  // idle cycles spent on the open request
  // code is only meaningful with the ack, scrambled otherwise
  assign mem_fault_code = FCODE ^ {16{~mem_ack}};
  ////////////////////////////////////////
  // memory: a quarter is its own address repeated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mw <= 2'h0;
      mem_ack <= 1'b0;
      mem_rdata <= '0;
      mem_fault <= 1'b0;
    end else if (mem_req && !mem_ack && mw >= (slow ? 2'h2 : 2'h0)) begin
      mw <= 2'h0;
      mem_ack <= 1'b1;
      mem_rdata <= {8{mem_addr}};
      mem_fault <= inject && mem_addr[7:6] == 2'h2;
    end else begin
      mw <= mem_req ? mw + 2'h1 : 2'h0;
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;  // no stale data outside the ack
      mem_fault <= ~mem_fault;
    end
  end
  // hash core: accepts one block per ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hw <= 2'h0;
      hash_ack <= 1'b0;
    end else if (hash_req && !hash_ack && hw >= (slow ? 2'h2 : 2'h0)) begin
      hw <= 2'h0;
      hash_ack <= 1'b1;
    end else begin
      hw <= hash_req ? hw + 2'h1 : 2'h0;
      hash_ack <= 1'b0;
    end
  end
endmodule // measure_extend_partner

// ===== verification/tb.sv
/*
  bench for the extend leaf: apb tasks, a model of hash stream and
  counter, a sweep over all fault causes. assumes the partner model.
*/
`timescale 1ns/1ps
`include "measure_extend_defines.svh"
module tb;
  import measure_extend_pkg::*;
  localparam logic [15:0] ERR = 16'h5A3C;  // partner fault code, arbitrary
  localparam logic [6:0]  FLIP [1:14] = '{0, 0, 0, 0, 1, 0, 2, 4, 8, 0, 16, 32, 64, 0};
  logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = `ZERO32, prdata, rv;
  logic         pready, pslverr, ev, mem_req, mem_ack, mem_fault, hash_req, hash_ack;
  logic [6:0]   chk = 7'h1B;  // cache, chunk, map busy, valid, owner, busy, init
  logic [7:0]   ptype = `PT_REGULAR;
  logic [63:0]  pea = `ZERO64, ebase = `ZERO64, mem_addr, update_count;
  logic [511:0] mem_rdata, hash_block;
  logic [15:0]  mem_fault_code;
  logic         slow = 1'b0, inject = 1'b0;
  logic [31:0]  seed = 32'hdb18_f722;
  longint       model_cnt = 0;  // reference update counter
  int           mismatches = 0, comparisons = 0;
  logic [511:0] obs[$], exq[$];  // hashed blocks seen and expected
  always #2.5 pclk = ~pclk;
  measure_extend_leaf dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ctl_in_cache(chk[0]), .chunk_in_cache(chk[1]),
    .map_busy(chk[2]), .chunk_entry_valid(chk[3]), .chunk_page_type(ptype),
    .owner_match(chk[4]), .measure_busy(chk[5]), .enclave_initialized(chk[6]),
    .page_enclave_addr(pea), .enclave_base(ebase), .mem_req, .mem_addr, .mem_ack,
    .mem_rdata, .mem_fault, .mem_fault_code, .hash_req, .hash_block, .hash_ack, .update_count);
  measure_extend_partner #(.FCODE(ERR)) far (.pclk, .presetn, .slow, .inject, .mem_req,
    .mem_addr, .mem_ack, .mem_rdata, .mem_fault, .mem_fault_code, .hash_req, .hash_ack);
  ////////////////////////////////////////
  // record every block the hash side accepts
  always @(posedge pclk) begin
    if (hash_req === 1'b1 && hash_ack === 1'b1) obs.push_back(hash_block);
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic cmp_word(input string nm, input logic [63:0] e, g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmp_blk(input logic [511:0] e, g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] hash_block exp %h got %h", e, g);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic er);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) mismatches++;
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // load operands, start, wait for done, compare against the model
  task automatic run(input logic [31:0] c, input logic [63:0] p, k, input logic [31:0] l,
                     input logic [3:0] cause);
    int          n;
    logic [31:0] st, ex, m;
    logic        pf, pfc;
    obs.delete();
    exq.delete();
    apb(1'b1, `OFS_CPTR_LO, p[31:0], rv, ev);
    apb(1'b1, `OFS_CPTR_HI, p[63:32], rv, ev);
    apb(1'b1, `OFS_CHUNK_LO, k[31:0], rv, ev);
    apb(1'b1, `OFS_CHUNK_HI, k[63:32], rv, ev);
    apb(1'b1, `OFS_SEG_LIMIT, l, rv, ev);
    apb(1'b1, `OFS_CTRL, c | 32'h1, rv, ev);
    n = 0;
    do begin
      apb(1'b0, `OFS_STATUS, `ZERO32, st, ev);
      n++;
    end while (st[`ST_DONE] !== 1'b1 && n < 100);
    pf = cause inside {4'h5, 4'h7, 4'h9, 4'hA, 4'hE};
    pfc = pf && cause != 4'h5;
    ex = {(cause == 4'hE) ? ERR : 16'h0, 4'h0, cause, 3'h0, pfc, pf, cause != 0 && !pf, 2'b10};
    m = (pf && cause != 4'hE) ? 32'h0000_0F1F : 32'hFFFF_0F1F;
    if (cause == C_NONE) begin
      exq.push_back({384'h0, pea - ebase + {52'h0, k[11:0]}, `HDR_TAG});
      for (int q = 0; q < 4; q++) exq.push_back({8{k + 64'(q * 64)}});
      model_cnt += 5;
    end
    cmp_word("status", {32'h0, ex & m},
             {32'h0, st & m});
    cmp_word("count", model_cnt, update_count);
    cmp_word("blocks", exq.size(), obs.size());
    for (int j = 0; j < exq.size() && j < obs.size(); j++) cmp_blk(exq[j], obs[j]);
    apb(1'b1, `OFS_STATUS, 32'h2, rv, ev);
    $display("run cause %0h done", cause);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // watchdog: over thirty times the expected run
  initial begin
    #100_000;
    mismatches++;
    $display("[FAIL] watchdog exp finish got timeout");
    final_report();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `OFS_STATUS, `ZERO32, rv, ev);
    cmp_word("status_reset", `ZERO64, {32'h0, rv});
    apb(1'b0, 8'h40, `ZERO32, rv, ev);
    cmp_word("unmapped_err", 64'h1, {63'h0, ev});
    $display("test registers done");
    for (int t = 1; t <= 4; t++) begin
      slow <= t[0];
      ptype <= 8'(t);
      pea <= {rnd(), rnd() & 32'hFFFF_F000};
      ebase <= {32'h0, rnd() & 32'h0FFF_F000};
      run(32'h2, 64'h1000, {32'h0004_0000 | (rnd() & 32'h0F00)}, 32'hFFFF_FFFF, C_NONE);
    end
    for (int i = 1; i <= 14; i++) begin
      slow <= i[0];
      inject <= (i == 14);
      chk <= 7'h1B ^ FLIP[i];
      ptype <= (i == 10) ? 8'h00 : `PT_THREAD_CTL;
      run((i == 1) ? 32'h12 : (i == 3) ? 32'h4 : 32'h2,
          (i == 2) ? 64'h0001_0000_0000_1000 : (i == 4) ? 64'h1080 : 64'h1000,
          (i == 6) ? 64'h2140 : 64'h2100, (i == 3) ? 32'h100 : 32'hFFFF_FFFF, 4'(i));
    end
    $display("test faults done");
    final_report();
  end
endmodule // tb
